// [hw/bpb_regs.svh]
// Purpose: Constants for the backplane boot and pass-through block handler.
// Assumes: Blocks travel as streams of 16-bit words, word 0 first.
// Notes: Identifier codes and block layout offsets live here.
`ifndef BPB_REGS_SVH
`define BPB_REGS_SVH
`define BPB_ID_WARM 16'h270E
`define BPB_ID_COLD 16'h270F
`define BPB_ID_PASS 16'h270C
`define BPB_FC_COIL 8'h05
`define BPB_FC_REG 8'h06
`define BPB_FC_COILS 8'h0F
`define BPB_FC_REGS 8'h10
`define BPB_IN_LAST 8'hF7
`define BPB_OUT_LAST 8'hF9
`define BPB_MSG_FIRST 8'h03
`define BPB_MSG_MAX 8'hF6
`define BPB_POS_COUNT 8'h02
`define BPB_POS_TRAIL 8'hF9
`define BPB_Q_DEPTH 2
`endif

// [hw/bpb_pkg.sv]
// Purpose: Types for the backplane boot and pass-through block handler.
// Assumes: Nothing beyond the constants header.
// Notes: Structs carry the word streams and the slave-port messages; an enum names the handler states.
package bpb_pkg;
  typedef enum logic [2:0] {
    BPB_IDLE = 3'b000,
    BPB_IN_BODY = 3'b001,
    BPB_OUT_SEND = 3'b010,
    BPB_WAIT_ACK = 3'b011,
    BPB_RELOAD = 3'b100
  } bpb_state_e;

  typedef struct packed {
    logic valid;
    logic last;
    logic [15:0] word;
  } bpb_word_s;

  typedef struct packed {
    logic valid;
    logic [7:0] count;
    logic [7:0] fcode;
  } bpb_msg_s;
endpackage

// [hw/bpb_block_handler.sv]
// Purpose: Decode output blocks from the processor and forward pass-through writes to it.
// Assumes: Blocks arrive as word streams on one 25 MHz clock; the message is read through an index port.
// Notes: Two-entry queue holds pending writes; the processor's ack block frees the head.
//
// Function
// - An incoming block with 9998 in word 0 starts a warm restart, a soft reset, not a hardware reset.
// - A warm restart fetches the configuration from the processor again and resumes with it.
// - An incoming block with 9999 in word 0 asserts a full hardware reset request.
// - Each write request on a pass-through slave port yields one block tagged 9996 to the processor.
// - Only function codes 5, 6, 15 and 16 are forwarded.
// - The forwarded block is 0, 9996, byte count, raw message in words 3 to 248, then 9996 in word 249.
// - That acknowledgement removes the pending write from the queue.
`include "bpb_regs.svh"
module bpb_block_handler (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Block stream from the processor
  input wire bpb_pkg::bpb_word_s i_in,
  output logic o_in_ready,
  // Block stream to the processor
  output bpb_pkg::bpb_word_s o_out,
  input wire logic i_out_ready,
  // Pass-through requests from the slave port
  input wire bpb_pkg::bpb_msg_s i_msg,
  input wire logic i_passthru_en,
  output logic o_msg_ready,
  output logic [7:0] o_msg_index,
  input wire logic [15:0] i_msg_word,
  // Restart control
  output logic o_warm_restart,
  output logic o_cfg_fetch,
  input wire logic i_cfg_done,
  output logic o_cold_reset
);
  import bpb_pkg::*;

  typedef struct packed {
    bpb_state_e state;
    logic in_first;
    logic in_ack;
    logic [7:0] pos;
    bpb_msg_s [`BPB_Q_DEPTH-1:0] q;
    logic [1:0] q_cnt;
    bpb_word_s out;
    logic warm;
    logic fetch;
    logic cold;
  } bpb_reg_s;

  bpb_reg_s r;
  bpb_reg_s next_r;
  logic out_take;
  logic in_take;
  logic fc_ok;

  // ----------------------------------------
  // Handshakes and outputs
  // ----------------------------------------
  assign out_take = o_out.valid && i_out_ready;
  assign in_take = i_in.valid && o_in_ready;
  assign o_in_ready = 1'b1;
  assign fc_ok = (i_msg.fcode == `BPB_FC_COIL) || (i_msg.fcode == `BPB_FC_REG) ||
                 (i_msg.fcode == `BPB_FC_COILS) || (i_msg.fcode == `BPB_FC_REGS);
  // Unsupported codes are taken and dropped so the port never stalls on them.
  assign o_msg_ready = (r.q_cnt < 2'(`BPB_Q_DEPTH)) || !fc_ok || !i_passthru_en;
  assign o_out = r.out;
  // The index leads pos by one, because the word fetched now is registered for the next beat.
  assign o_msg_index = r.pos + 8'h01 - `BPB_MSG_FIRST;
  assign o_warm_restart = r.warm;
  assign o_cfg_fetch = r.fetch;
  assign o_cold_reset = r.cold;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic pop;
    logic [15:0] w;
    pop = 1'b0;
    w = 16'h0000;
    next_r = r;
    next_r.warm = 1'b0;
    // Input block decode.
    if (in_take) begin
      if (r.in_first) begin
        next_r.in_ack = 1'b0;
        // A warm request during a reload is ignored, since the fetch in flight picks up the newest data.
        if (i_in.word == `BPB_ID_WARM && r.state != BPB_RELOAD) begin
          next_r.warm = 1'b1;
          next_r.fetch = 1'b1;
        end
        // Cold reset stays up until the external reset clears it, so a short request is never lost.
        if (i_in.word == `BPB_ID_COLD) begin
          next_r.cold = 1'b1;
        end
        // An ack counts only after a whole block has gone out, so a stray one cannot free an unseen write.
        if (i_in.word == `BPB_ID_PASS && r.state == BPB_WAIT_ACK) begin
          next_r.in_ack = 1'b1;
        end
      end
      next_r.in_first = i_in.last;
      if (i_in.last && (r.in_ack || (r.in_first && i_in.word == `BPB_ID_PASS && r.state == BPB_WAIT_ACK))) begin
        pop = 1'b1;
      end
    end
    case (r.state)
      BPB_IDLE: begin
        // Pending blocks wait while a fetch is pending, so none goes out with stale settings.
        if (r.q_cnt != 2'h0 && !r.fetch) begin
          next_r.state = BPB_OUT_SEND;
          next_r.pos = 8'h00;
          next_r.out.valid = 1'b1;
          next_r.out.last = 1'b0;
          next_r.out.word = 16'h0000;
        end else if (r.fetch) begin
          next_r.state = BPB_RELOAD;
        end
      end
      BPB_OUT_SEND: begin
        if (out_take) begin
          next_r.pos = r.pos + 8'h01;
          if (r.pos + 8'h01 == 8'h01) begin
            w = `BPB_ID_PASS;
          end else if (r.pos + 8'h01 == `BPB_POS_COUNT) begin
            w = {8'h00, r.q[0].count};
          end else if (r.pos + 8'h01 == `BPB_POS_TRAIL) begin
            w = `BPB_ID_PASS;
          end else if (r.pos + 8'h01 - `BPB_MSG_FIRST < r.q[0].count) begin
            w = i_msg_word;
          end
          next_r.out.word = w;
          next_r.out.last = (r.pos + 8'h01 == `BPB_OUT_LAST);
          if (r.out.last) begin
            next_r.out.valid = 1'b0;
            next_r.state = BPB_WAIT_ACK;
          end
        end
      end
      BPB_WAIT_ACK: begin
        if (pop) begin
          next_r.state = BPB_IDLE;
        end
      end
      BPB_RELOAD: begin
        if (i_cfg_done) begin
          next_r.fetch = 1'b0;
          next_r.state = BPB_IDLE;
        end
      end
      default: begin
        next_r.state = BPB_IDLE;
      end
    endcase
    // Queue: pop shifts head out, push appends at tail, so order is kept.
    if (pop && r.q_cnt != 2'h0) begin
      next_r.q[0] = r.q[1];
      next_r.q[1] = '0;
      next_r.q_cnt = r.q_cnt - 2'h1;
    end
    if (i_msg.valid && o_msg_ready && fc_ok && i_passthru_en) begin
      next_r.q[next_r.q_cnt[0]] = i_msg;
      next_r.q_cnt = next_r.q_cnt + 2'h1;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r <= '0;
      r.in_first <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_warm_soft: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_warm_restart |-> $stable(o_cold_reset)) else $error("warm restart changed cold reset");
  a_warm_fetch: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_warm_restart |-> o_cfg_fetch) else $error("warm restart without config fetch");
  a_reload_quiet: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (r.state == BPB_RELOAD) |-> !o_out.valid) else $error("block sent during reload");
  a_cold_sticky: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (in_take && r.in_first && i_in.word == `BPB_ID_COLD) |=> o_cold_reset) else $error("cold reset missed");
  a_cold_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $past(o_cold_reset) |-> o_cold_reset) else $error("cold reset dropped");
  a_out_head: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_out.valid) |-> o_out.word == 16'h0000 && r.pos == 8'h00) else $error("bad block start");
  a_fc_filter: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_msg.valid && !fc_ok) |=> r.q_cnt <= $past(r.q_cnt)) else $error("bad code queued");
  a_head_tag: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (o_out.valid && r.pos == 8'h01) |-> o_out.word == `BPB_ID_PASS) else $error("bad tag word");
  a_count_word: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (o_out.valid && r.pos == `BPB_POS_COUNT) |-> o_out.word == {8'h00, r.q[0].count}) else $error("bad count");
  a_trail_tag: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (o_out.valid && o_out.last) |-> o_out.word == `BPB_ID_PASS) else $error("bad trailer");
  a_out_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (o_out.valid && !i_out_ready) |=> $stable(o_out)) else $error("word changed while stalled");
  a_ack_pop: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (r.state == BPB_WAIT_ACK && next_r.state == BPB_IDLE) |=>
    (r.q_cnt < $past(r.q_cnt) || $past(i_msg.valid && o_msg_ready))) else $error("ack did not free entry");
  a_q_bound: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    r.q_cnt <= 2'(`BPB_Q_DEPTH)) else $error("queue overflow");

  // Covers mark a forwarded block, both restart kinds, a full queue and a finished reload.
  c_pass: cover property (@(posedge i_clk) disable iff (!i_reset_n) o_out.valid && o_out.last && i_out_ready);
  c_warm: cover property (@(posedge i_clk) disable iff (!i_reset_n) o_warm_restart);
  c_full: cover property (@(posedge i_clk) disable iff (!i_reset_n) r.q_cnt == 2'h2);
  c_cold: cover property (@(posedge i_clk) disable iff (!i_reset_n) $rose(o_cold_reset));
  c_reload: cover property (@(posedge i_clk) disable iff (!i_reset_n) r.state == BPB_RELOAD && i_cfg_done);
endmodule // bpb_block_handler

// [tb/bpb_proc_model.sv]
// Purpose: Processor side that takes forwarded blocks word by word.
// Assumes: A word is taken on a rising edge with valid and ready high.
// Notes: Slow mode drops ready every other cycle to stall the sender.
module bpb_proc_model (
  // Clock and control
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_slow,
  input wire logic i_clear,
  // Forwarded stream
  input wire bpb_pkg::bpb_word_s i_out,
  output logic o_ready,
  output logic [15:0] o_words [0:255],
  output logic [8:0] o_count
);
  timeunit 1ns;
  timeprecision 1ns;
  import bpb_pkg::*;
  always @(negedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) o_ready <= 1'b1;
    else o_ready <= !i_slow || !o_ready;
  end
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) o_count <= 9'h000;
    else if (i_clear) o_count <= 9'h000;
    else if (i_out.valid && o_ready) begin
      o_words[o_count[7:0]] <= i_out.word;
      o_count <= o_count + 9'h001;
    end
  end
endmodule // bpb_proc_model

// [tb/tb_bpb_block_handler.sv]
// Purpose: Self-checking bench for the block handler.
// Assumes: Inputs change on falling edges only.
// Notes: Message words are the head's tag and the message word index.
`include "bpb_regs.svh"
module tb_bpb_block_handler;
  timeunit 1ns;
  timeprecision 1ns;
  import bpb_pkg::*;
  logic i_clk = 1'b0, i_reset_n = 1'b0, i_out_ready, i_passthru_en = 1'b1, o_in_ready, o_msg_ready;
  logic o_warm_restart, o_cfg_fetch, i_cfg_done, o_cold_reset, slow, clear;
  bpb_word_s i_in, o_out;
  bpb_msg_s i_msg;
  logic [7:0] o_msg_index, tag, tag2;
  logic [15:0] words [0:255];
  logic [8:0] count;
  int err_total = 0, checks = 0, warm_n = 0;
  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_warm_restart === 1'b1) warm_n++;
  bpb_block_handler bpb_block_handler_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_in(i_in),
    .o_in_ready(o_in_ready), .o_out(o_out), .i_out_ready(i_out_ready), .i_msg(i_msg),
    .i_passthru_en(i_passthru_en), .o_msg_ready(o_msg_ready), .o_msg_index(o_msg_index),
    .i_msg_word({tag, o_msg_index}), .o_warm_restart(o_warm_restart), .o_cfg_fetch(o_cfg_fetch),
    .i_cfg_done(i_cfg_done), .o_cold_reset(o_cold_reset));
  bpb_proc_model bpb_proc_model_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_slow(slow),
    .i_clear(clear), .i_out(o_out), .o_ready(i_out_ready), .o_words(words), .o_count(count));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    if (err_total == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic send_block(input logic [15:0] id);
    for (int k = 0; k < 248; k++) begin
      i_in <= '{1'b1, k == 247, k == 0 ? id : 16'h5A5A};
      @(negedge i_clk);
    end
    i_in <= '0;
  endtask
  task automatic push(input logic [7:0] fc, input logic [7:0] cnt);
    i_msg <= '{1'b1, cnt, fc};
    @(negedge i_clk);
    i_msg <= '0;
    @(negedge i_clk);
  endtask
  // Waits for a whole forwarded block, checks it and acknowledges it.
  task automatic recv(input logic [7:0] t, input logic [7:0] cnt);
    logic [15:0] e;
    for (int n = 0; count !== 9'd250; n++) begin
      if (n == 2000) begin
        chk("block words", 16'd250, {7'h0, count});
        conclude();
      end
      @(negedge i_clk);
    end
    for (int p = 0; p < 250; p++) begin
      e = (p == 1 || p == 249) ? `BPB_ID_PASS : p == 2 ? {8'h00, cnt} : (p >= 3 && p < 3 + cnt) ? {t, 8'(p - 3)} : 16'h0;
      chk("out word", e, words[p]);
    end
    chk("in ready", 16'h1, {15'h0, o_in_ready});
    clear <= 1'b1;
    send_block(`BPB_ID_PASS);
    clear <= 1'b0;
    tag <= tag2;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic sc_order();
    slow <= 1'b1;
    tag <= 8'h11;
    tag2 <= 8'h22;
    push(`BPB_FC_REG, 8'h08);
    push(`BPB_FC_REGS, `BPB_MSG_MAX);
    i_msg <= '{1'b1, 8'h08, `BPB_FC_COIL};
    #1 chk("msg ready when full", 16'h0, {15'h0, o_msg_ready});
    @(negedge i_clk);
    i_msg <= '0;
    @(negedge i_clk);
    recv(8'h11, 8'h08);
    recv(8'h22, `BPB_MSG_MAX);
  endtask
  task automatic sc_codes();
    slow <= 1'b0;
    tag <= 8'h33;
    tag2 <= 8'h44;
    push(`BPB_FC_COIL, 8'h04);
    recv(8'h33, 8'h04);
    push(`BPB_FC_COILS, 8'h07);
    recv(8'h44, 8'h07);
  endtask
  task automatic sc_drop();
    i_passthru_en <= 1'b0;
    push(`BPB_FC_REG, 8'h04);
    i_passthru_en <= 1'b1;
    push(8'h03, 8'h04);
    repeat (20) @(negedge i_clk);
    chk("dropped words", 16'h0, {7'h0, count});
  endtask
  task automatic sc_boot();
    tag <= 8'h66;
    send_block(`BPB_ID_WARM);
    chk("warm pulses", 16'h1, 16'(warm_n));
    chk("cfg fetch", 16'h1, {15'h0, o_cfg_fetch});
    push(`BPB_FC_REG, 8'h02);
    repeat (10) @(negedge i_clk);
    chk("words in reload", 16'h0, {7'h0, count});
    i_cfg_done <= 1'b1;
    @(negedge i_clk);
    @(negedge i_clk);
    i_cfg_done <= 1'b0;
    chk("cfg fetch done", 16'h0, {15'h0, o_cfg_fetch});
    recv(8'h66, 8'h02);
    chk("cold after warm", 16'h0, {15'h0, o_cold_reset});
    send_block(`BPB_ID_COLD);
    repeat (5) @(negedge i_clk);
    chk("cold level", 16'h1, {15'h0, o_cold_reset});
    chk("warm pulses", 16'h1, 16'(warm_n));
    i_reset_n <= 1'b0;
    @(negedge i_clk);
    i_reset_n <= 1'b1;
    @(negedge i_clk);
    chk("cold after reset", 16'h0, {15'h0, o_cold_reset});
  endtask
  initial begin
    i_in = '0;
    i_msg = '0;
    i_cfg_done = 1'b0;
    slow = 1'b0;
    clear = 1'b0;
    tag = 8'h00;
    tag2 = 8'h00;
    repeat (12) @(negedge i_clk);
    i_reset_n <= 1'b1;
    @(negedge i_clk);
    sc_order();
    sc_codes();
    sc_drop();
    sc_boot();
    conclude();
  end
endmodule // tb_bpb_block_handler
